//--- rtl/bss_brake_stop_sequencer.sv
// brake stop sequencer: stop method, brake hold timing, avalon registers
//
// Behaviour
// - alarm removes motor current immediately
// - rotating stop uses speed and wait conditions
// - brake after servo off below speed level
// - any engage condition drives brake high
// - method 0 reverse brakes then coasts
// - method 1 coasts without reverse braking
// - stop on servo-on inactive or power loss
// - power loss forces reverse braking stop
// - alarm always stops by coasting
// - speed level clipped to motor maximum
// - brake output low releases, high holds
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// overview
// the host servo-on, the two power-good pins and the alarm pin are
// asynchronous and pass two flip-flops before any logic reads them.
// motor speed comes from the speed loop on this clock and is used as is.
// the sequencer has three states: run, reverse braking and coasting.
// the brake hold level is a flip-flop so the relay never sees a glitch.
// current enable and stop torque are combinational so an alarm cuts the
// motor current in the same cycle as the synchronised alarm appears.
// software sees the configuration, a live status word, sticky events
// and their mask over avalon-mm; every access takes one wait cycle.
// hazard: a speed level of zero never engages the brake by speed, only
// the waiting time does; the waiting time is clipped to 10..100 units.
// limitation: leaving reverse braking needs standstill or an alarm, so a
// servo-on during reverse braking waits until the motor has stopped.
module bss_brake_stop_sequencer
    import bss_pkg::*;
#(
    parameter int TICK_CYC = BSS_TICK_CYC // cycles per 10 ms
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic [5:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire logic                 servo_on_i,
    input  wire logic                 main_pwr_ok_i,
    input  wire logic                 ctrl_pwr_ok_i,
    input  wire logic                 alarm_i,
    input  wire logic [BSS_SPD_W-1:0] motor_speed_i,
    output logic                      current_en_o,
    output logic                      rev_brake_o,
    output logic                      brake_hold_output_o,
    output logic                      rotation_detect_output_o,
    output logic                      irq_o
);
    // ==================================================
    // pin synchronisers
    // reset values: servo off, both supplies present, no alarm, so the
    // sequencer does not see a false power loss while reset is released
    logic [3:0] pin_meta_ff; // first stage, read by second only
    logic [3:0] pin_ff;      // {alarm, ctrl ok, main ok, servo on}
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_meta_ff <= 4'h6;
            pin_ff      <= 4'h6;
        end else begin
            pin_meta_ff <= {alarm_i, ctrl_pwr_ok_i, main_pwr_ok_i, servo_on_i};
            pin_ff      <= pin_meta_ff;
        end
    end
    wire logic servo_on = pin_ff[0]; // host servo-on
    wire logic pwr_lost = !pin_ff[1] || !pin_ff[2]; // main or control off
    wire logic alarm    = pin_ff[3]; // drive alarm
    wire logic stop_req = !servo_on || pwr_lost || alarm;

    // ==================================================
    // registers
    bss_cfg_s              cfg_ff;   // software configuration
    logic [BSS_EV_W-1:0]   irqs_ff;  // sticky events
    logic [BSS_EV_W-1:0]   irqm_ff;  // mask, 1 enables
    logic                  ack_ff;   // answer cycle of a bus access
    logic [31:0]           rdata_ff; // latched read data
    bss_state_e            state_ff; // stop sequencer state
    bss_state_e            nxt_state;
    logic                  brake_ff; // brake hold level
    logic                  rot_ff;   // rotation seen
    logic [17:0]           tick_cnt_ff; // 10 ms divider
    logic [BSS_WAIT_W-1:0] wait_cnt_ff; // elapsed 10 ms units

    // ==================================================
    // bus decode
    wire logic access   = avs_read_i || avs_write_i;
    wire logic wr_take  = avs_write_i && ack_ff; // write lands here
    wire logic sel_ctrl = avs_address_i == BSS_CTRL_OFS;
    wire logic sel_spd  = avs_address_i == BSS_SPEED_OFS;
    wire logic sel_wait = avs_address_i == BSS_WAIT_OFS;
    wire logic sel_max  = avs_address_i == BSS_MAX_OFS;
    wire logic sel_irqs = avs_address_i == BSS_IRQS_OFS;
    wire logic sel_irqm = avs_address_i == BSS_IRQM_OFS;
    wire logic [BSS_SPD_W-1:0] wd_spd   = avs_writedata_i[BSS_SPD_W-1:0];
    wire logic [BSS_WAIT_W-1:0] wd_wait = avs_writedata_i[BSS_WAIT_W-1:0];

    // clamp a value into a range
    function automatic logic [BSS_SPD_W-1:0] clip(
        input logic [BSS_SPD_W-1:0] v,
        input logic [BSS_SPD_W-1:0] lo,
        input logic [BSS_SPD_W-1:0] hi);
        if (v < lo) begin
            return lo;
        end
        return (v > hi) ? hi : v;
    endfunction

    wire logic [BSS_SPD_W-1:0] wait_clip = clip({6'h00, wd_wait},
        {6'h00, BSS_WAIT_MIN}, {6'h00, BSS_WAIT_MAX});

    // read mux
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000; // unmapped reads zero
        case (avs_address_i)
            BSS_CTRL_OFS:  rmux[0] = cfg_ff.stop_coast;
            BSS_SPEED_OFS: rmux[BSS_SPD_W-1:0] = cfg_ff.brk_speed;
            BSS_WAIT_OFS:  rmux[BSS_WAIT_W-1:0] = cfg_ff.brk_wait;
            BSS_MAX_OFS:   rmux[BSS_SPD_W-1:0] = cfg_ff.max_speed;
            BSS_STAT_OFS:  rmux[5:0] = {rot_ff, brake_ff, current_en_o,
                                        rev_brake_o, state_ff};
            BSS_IRQS_OFS:  rmux[BSS_EV_W-1:0] = irqs_ff;
            BSS_IRQM_OFS:  rmux[BSS_EV_W-1:0] = irqm_ff;
            default:       rmux = 32'h0000_0000;
        endcase
    end

    // one wait cycle then answer
    // ack_ff rises for the second cycle of every access; read data are
    // latched at the end of the first cycle and stand in the second
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= access && !ack_ff;
            rdata_ff <= rmux;
        end
    end
    assign avs_waitrequest_o = access && !ack_ff;
    assign avs_readdata_o    = rdata_ff;

    // configuration writes, speed level and waiting time clipped, motor maximum taken as written
    // a write lands only at the edge that ends its answer cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_ff <= '{1'b0, BSS_SPEED_RST, BSS_WAIT_RST, BSS_MAX_RST};
            irqm_ff <= 3'h0;
        end else if (wr_take) begin
            if (sel_ctrl) begin
                cfg_ff.stop_coast <= avs_writedata_i[0];
            end
            if (sel_spd) begin
                cfg_ff.brk_speed <= clip(wd_spd, 13'h0000, BSS_SPEED_MAX);
            end
            if (sel_wait) begin
                cfg_ff.brk_wait <= wait_clip[BSS_WAIT_W-1:0];
            end
            if (sel_max) begin
                cfg_ff.max_speed <= wd_spd;
            end
            if (sel_irqm) begin
                irqm_ff <= avs_writedata_i[BSS_EV_W-1:0];
            end
        end
    end

    // ==================================================
    // stop method selection
    // priority: alarm coasts, power loss reverse brakes, then the method
    // field decides for a plain servo off
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            BSS_RUN: begin
                if (alarm) begin
                    nxt_state = BSS_COAST;
                end else if (pwr_lost) begin
                    nxt_state = BSS_DECEL;
                end else if (!servo_on) begin
                    nxt_state = cfg_ff.stop_coast ? BSS_COAST : BSS_DECEL;
                end
            end
            BSS_DECEL: begin
                if (alarm || motor_speed_i == 13'h0000) begin
                    nxt_state = BSS_COAST;
                end
            end
            BSS_COAST: begin
                if (!stop_req) begin
                    nxt_state = BSS_RUN; // servo on again
                end
            end
            default: nxt_state = BSS_COAST;
        endcase
    end

    // state register; reset leaves the motor unpowered with brake held
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= BSS_COAST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // alarm cuts current without waiting for the state register
    assign current_en_o = (state_ff != BSS_COAST) && !alarm;
    assign rev_brake_o  = (state_ff == BSS_DECEL) && !alarm;

    // ==================================================
    // brake timing while the motor may still turn
    // the divider and the wait counter restart on every return to run,
    // so the waiting time is measured from the servo off edge
    wire logic tick = tick_cnt_ff == 18'(TICK_CYC - 1);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || state_ff == BSS_RUN) begin
            tick_cnt_ff <= 18'h00000;
            wait_cnt_ff <= 7'h00;
        end else begin
            tick_cnt_ff <= tick ? 18'h00000 : tick_cnt_ff + 18'h00001;
            if (tick && wait_cnt_ff != BSS_WAIT_MAX) begin
                wait_cnt_ff <= wait_cnt_ff + 7'h01;
            end
        end
    end

    // speed level never above the motor's own top speed
    wire logic [BSS_SPD_W-1:0] lvl_eff = clip(cfg_ff.brk_speed, 13'h0000,
                                              cfg_ff.max_speed);
    wire logic slow_enough = motor_speed_i < lvl_eff;
    wire logic waited      = wait_cnt_ff >= cfg_ff.brk_wait;
    wire logic engage      = nxt_state != BSS_RUN
                           && (slow_enough || waited);

    // brake high holds, low releases
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            brake_ff <= 1'b1; // held until servo on
            rot_ff   <= 1'b0;
        end else begin
            rot_ff <= motor_speed_i != 13'h0000;
            if (nxt_state == BSS_RUN) begin
                brake_ff <= 1'b0;
            end else if (engage) begin
                brake_ff <= 1'b1;
            end
        end
    end
    assign brake_hold_output_o      = brake_ff;
    assign rotation_detect_output_o = rot_ff;

    // ==================================================
    // interrupts, set wins over clear
    wire logic [BSS_EV_W-1:0] ev_set = {engage && !brake_ff,
        state_ff == BSS_RUN && nxt_state == BSS_DECEL && pwr_lost,
        state_ff != BSS_COAST && alarm};
    wire logic [BSS_EV_W-1:0] ev_clr = (wr_take && sel_irqs)
                                     ? avs_writedata_i[BSS_EV_W-1:0] : 3'h0;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irqs_ff <= 3'h0;
        end else begin
            irqs_ff <= (irqs_ff & ~ev_clr) | ev_set;
        end
    end
    assign irq_o = |(irqs_ff & irqm_ff);

    // ==================================================
    // checks
    a_alarm_no_current: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        alarm |-> !current_en_o)
        else $error("current on during alarm");
    a_alarm_coasts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        alarm |=> state_ff == BSS_COAST)
        else $error("alarm did not coast");
    a_pwr_rev_brake: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && pwr_lost && !alarm |=> rev_brake_o || alarm)
        else $error("power loss not reverse braked");
    a_method_coast: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && !servo_on && cfg_ff.stop_coast && !pwr_lost
        |=> state_ff == BSS_COAST)
        else $error("method 1 did not coast");
    a_method_decel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && stop_req && !cfg_ff.stop_coast && !alarm
        |=> state_ff == BSS_DECEL)
        else $error("method 0 did not reverse brake");
    a_decel_to_coast: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_DECEL && motor_speed_i == 13'h0000 |=> state_ff == BSS_COAST)
        else $error("no coast after standstill");
    a_slow_brakes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff != BSS_RUN && !servo_on && motor_speed_i < lvl_eff |=> brake_hold_output_o)
        else $error("brake not held below speed level");
    a_level_clipped: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lvl_eff <= cfg_ff.max_speed && lvl_eff <= cfg_ff.brk_speed)
        else $error("speed level above motor maximum");
    a_wait_brakes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff != BSS_RUN && !servo_on && wait_cnt_ff >= cfg_ff.brk_wait
        |=> brake_hold_output_o)
        else $error("brake not held after waiting time");
    a_run_releases: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && $past(state_ff) == BSS_RUN |-> !brake_hold_output_o)
        else $error("brake held while running");
    // reverse braking keeps current on and applies the stop torque
    a_decel_torque: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_DECEL && !alarm |-> rev_brake_o && current_en_o)
        else $error("reverse braking without stop torque");
    // coasting leaves the motor unpowered and without stop torque
    a_coast_unpowered: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_COAST |-> !current_en_o && !rev_brake_o)
        else $error("coasting motor still powered");
    // any stop request leaves run at the next edge
    a_stop_leaves_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && stop_req |=> state_ff != BSS_RUN)
        else $error("stop request ignored");
    // a motor already slow at the stop request is braked at once
    a_rotating_slow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && stop_req && motor_speed_i < lvl_eff |=> brake_hold_output_o)
        else $error("slow motor not braked at stop");
    // once held, the brake stays held until the return to run
    a_brake_stays: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        brake_hold_output_o && nxt_state != BSS_RUN |=> brake_hold_output_o)
        else $error("brake released outside run");
    // a power loss stop is reported as an event
    a_pwr_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff == BSS_RUN && pwr_lost && !alarm |=> irqs_ff[BSS_EV_PWR])
        else $error("power loss event not recorded");
endmodule
`default_nettype wire

//--- rtl/bss_pkg.sv
// package: constants, types and register map of the brake stop sequencer
package bss_pkg;
    // ==================================================
    // register byte offsets
    localparam logic [5:0] BSS_CTRL_OFS  = 6'h00; // stop method
    localparam logic [5:0] BSS_SPEED_OFS = 6'h04; // brake speed level
    localparam logic [5:0] BSS_WAIT_OFS  = 6'h08; // brake waiting time
    localparam logic [5:0] BSS_MAX_OFS   = 6'h0c; // motor maximum speed
    localparam logic [5:0] BSS_STAT_OFS  = 6'h10; // live state, read only
    localparam logic [5:0] BSS_IRQS_OFS  = 6'h14; // sticky events, w1c
    localparam logic [5:0] BSS_IRQM_OFS  = 6'h18; // event mask
    // ==================================================
    // field positions and widths
    localparam int BSS_SPD_W      = 13;  // r/min, covers 0..6000
    localparam int BSS_WAIT_W     = 7;   // 10 ms units, 10..100
    localparam int BSS_EV_W       = 3;   // event count
    localparam int BSS_EV_ALARM   = 0;   // alarm coast stop
    localparam int BSS_EV_PWR     = 1;   // power loss stop
    localparam int BSS_EV_BRAKE   = 2;   // brake engaged
    // ==================================================
    // reset values and limits
    localparam logic [BSS_SPD_W-1:0]  BSS_SPEED_RST = 13'h0064; // 100
    localparam logic [BSS_WAIT_W-1:0] BSS_WAIT_RST  = 7'h32;    // 50
    localparam logic [BSS_SPD_W-1:0]  BSS_MAX_RST   = 13'h1770; // 6000
    localparam logic [BSS_SPD_W-1:0]  BSS_SPEED_MAX = 13'h1770; // 6000
    localparam logic [BSS_WAIT_W-1:0] BSS_WAIT_MIN  = 7'h0a;    // 10
    localparam logic [BSS_WAIT_W-1:0] BSS_WAIT_MAX  = 7'h64;    // 100
    // ==================================================
    // timing
    localparam int BSS_CLK_HZ    = 25000000;
    localparam int BSS_WAIT_UNIT_MS = 10;
    localparam int BSS_TICK_CYC  = BSS_CLK_HZ / 1000 * BSS_WAIT_UNIT_MS;
    // ==================================================
    // types
    typedef enum logic [1:0] {
        BSS_RUN,   // powered, brake released
        BSS_DECEL, // reverse braking with stop torque
        BSS_COAST  // unpowered, coasting or at rest
    } bss_state_e;
    typedef struct packed {
        logic                  stop_coast; // 0 reverse brake, 1 coast
        logic [BSS_SPD_W-1:0]  brk_speed;  // brake speed level
        logic [BSS_WAIT_W-1:0] brk_wait;   // waiting time, 10 ms units
        logic [BSS_SPD_W-1:0]  max_speed;  // motor own top speed
    } bss_cfg_s;
endpackage

//--- sim/bss_brake_relay_model.sv
// external brake relay model driven by the brake hold output
`timescale 1ns/1ns
`default_nettype none
module bss_brake_relay_model #(
    parameter int PICK_CYC = 3 // coil to contact delay
) (
    input  wire logic clk_i,
    input  wire logic coil_i, // high level holds the brake
    output logic      held_o  // brake mechanically holding
);
    // ==================================================
    // contact follows the coil after a fixed delay
    logic [PICK_CYC-1:0] pipe_ff; // coil history, settles during reset
    // shift the coil level in; the brake spring holds at high
    always_ff @(posedge clk_i) begin
        pipe_ff <= {pipe_ff[PICK_CYC-2:0], coil_i};
    end
    assign held_o = pipe_ff[PICK_CYC-1];
endmodule
`default_nettype wire

//--- sim/bss_brake_stop_sequencer_bench.sv
// self-checking bench of the brake stop sequencer
`timescale 1ns/1ns
`default_nettype none
module bss_brake_stop_sequencer_bench;
    import bss_pkg::*;
    // ==================================================
    // stimulus, observation and counters
    logic                 clk_i, sys_rst_i, avs_read_i, avs_write_i;
    logic                 servo_on_i, main_pwr_ok_i, ctrl_pwr_ok_i, alarm_i;
    logic [5:0]           avs_address_i;
    logic [31:0]          avs_writedata_i, avs_readdata_o;
    logic [BSS_SPD_W-1:0] motor_speed_i;
    logic                 avs_waitrequest_o, current_en_o, rev_brake_o, irq_o;
    logic                 brake_hold_output_o, rotation_detect_output_o, held;
    int                   errors, total_checks;
    logic                 wait_q;  // waitrequest as it stands before each rising edge
    logic [31:0]          rdat_q;  // read data as they stand before each rising edge
    bss_brake_stop_sequencer #(.TICK_CYC(4)) dut (.clk_i, .sys_rst_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
        .servo_on_i, .main_pwr_ok_i, .ctrl_pwr_ok_i, .alarm_i, .motor_speed_i, .current_en_o,
        .rev_brake_o, .brake_hold_output_o, .rotation_detect_output_o, .irq_o);
    bss_brake_relay_model relay (.clk_i, .coil_i(brake_hold_output_o), .held_o(held));
    // ==================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // nothing the bus sees changes between a falling and the next rising edge
    always @(negedge clk_i) begin
        wait_q = avs_waitrequest_o;
        rdat_q = avs_readdata_o;
    end
    // one avalon access, held until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (wait_q !== 1'b0 && n < 50);
        if (wait_q !== 1'b0) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, wait_q, 1'b0);
        end
        q = rdat_q;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    // bring the motor up to running at the given speed
    task automatic go_run(input logic [BSS_SPD_W-1:0] spd);
        @(posedge clk_i);
        motor_speed_i <= spd;
        servo_on_i <= 1'b1;
        for (int i = 0; i < 20 && (current_en_o !== 1'b1 || rev_brake_o !== 1'b0); i++) @(posedge clk_i);
        wt(1);
        chk(brake_hold_output_o, 1'b0);
        wt(3);
        chk(held, 1'b0);
    endtask
    task automatic servo_off;
        @(posedge clk_i);
        servo_on_i <= 1'b0;
        wt(6);
    endtask
    // ==================================================
    // scenarios
    task automatic t_regs;
        rd(BSS_STAT_OFS, 32'h12);
        rd(BSS_SPEED_OFS, 32'h64);
        wr(BSS_SPEED_OFS, 32'h1b58);
        rd(BSS_SPEED_OFS, 32'h1770);
        rd(6'h1c, 32'h0);
        wr(BSS_SPEED_OFS, 32'h64);
    endtask
    // reverse braking, brake only once slow, coast at standstill
    task automatic t_rev;
        wr(BSS_CTRL_OFS, 32'h0);
        go_run(13'h01f4);
        servo_off();
        chk(rev_brake_o, 1'b1);
        chk(brake_hold_output_o, 1'b0);
        motor_speed_i <= 13'h0032;
        wt(4);
        chk(brake_hold_output_o, 1'b1);
        wt(4);
        chk(held, 1'b1);
        motor_speed_i <= 13'h0000;
        wt(4);
        chk(current_en_o, 1'b0);
    endtask
    task automatic t_coast;
        wr(BSS_CTRL_OFS, 32'h1);
        go_run(13'h0032);
        servo_off();
        chk(rev_brake_o, 1'b0);
        chk(current_en_o, 1'b0);
        chk(brake_hold_output_o, 1'b1);
    endtask
    // fast motor: brake only after the waiting time
    task automatic t_wait;
        wr(BSS_CTRL_OFS, 32'h0);
        wr(BSS_WAIT_OFS, 32'h0a);
        go_run(13'h01f4);
        servo_off();
        wt(28);
        chk(brake_hold_output_o, 1'b0);
        wt(30);
        chk(brake_hold_output_o, 1'b1);
        motor_speed_i <= 13'h0000;
        wt(4);
        chk(current_en_o, 1'b0);
    endtask
    // power loss with coast selected still reverse brakes
    task automatic t_pwr(input logic sel);
        wr(BSS_CTRL_OFS, 32'h1);
        wr(BSS_IRQM_OFS, 32'h2);
        go_run(13'h01f4);
        wr(BSS_IRQS_OFS, 32'h7);
        if (sel) begin
            main_pwr_ok_i <= 1'b0;
        end else begin
            ctrl_pwr_ok_i <= 1'b0;
        end
        wt(5);
        chk(rev_brake_o, 1'b1);
        chk(irq_o, 1'b1);
        wr(BSS_IRQS_OFS, 32'h2);
        wt(1);
        chk(irq_o, 1'b0);
        main_pwr_ok_i <= 1'b1;
        ctrl_pwr_ok_i <= 1'b1;
        motor_speed_i <= 13'h0000;
        wt(2);
    endtask
    // alarm cuts current at once and coasts; its event is masked
    task automatic t_alarm;
        wr(BSS_CTRL_OFS, 32'h0);
        go_run(13'h01f4);
        alarm_i <= 1'b1;
        wt(3);
        chk(current_en_o, 1'b0);
        chk(rev_brake_o, 1'b0);
        chk(irq_o, 1'b0);
        alarm_i <= 1'b0;
    endtask
    // speed level above motor top speed is clipped to it
    task automatic t_max;
        wr(BSS_MAX_OFS, 32'hc8);
        wr(BSS_SPEED_OFS, 32'h3e8);
        wr(BSS_WAIT_OFS, 32'h64);
        go_run(13'h012c);
        servo_off();
        chk(brake_hold_output_o, 1'b0);
        motor_speed_i <= 13'h0096;
        wt(4);
        chk(brake_hold_output_o, 1'b1);
    endtask
    // ==================================================
    // verdict, clock, watchdog and main sequence
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        wt(6000);
        errors++;
        give_verdict();
    end
    initial begin
        {avs_read_i, avs_write_i, servo_on_i, alarm_i, errors, total_checks} = '0;
        {main_pwr_ok_i, ctrl_pwr_ok_i, sys_rst_i} = 3'b111;
        {avs_address_i, avs_writedata_i, motor_speed_i} = '0;
        wt(8);
        sys_rst_i <= 1'b0;
        chk(brake_hold_output_o, 1'b1);
        t_regs();
        t_rev();
        t_coast();
        t_wait();
        t_pwr(1'b1);
        t_pwr(1'b0);
        t_alarm();
        t_max();
        give_verdict();
    end
endmodule
`default_nettype wire
